//--- common/rtc_pkg.sv
// Constants for the clock output and time access block
package rtc_pkg;
    // Register offsets (byte addresses, 8-bit data)
    localparam logic [7:0] OFS_SEC    = 8'h00;
    localparam logic [7:0] OFS_MIN    = 8'h01;
    localparam logic [7:0] OFS_HOUR   = 8'h02;
    localparam logic [7:0] OFS_TLAST  = 8'h06;
    localparam logic [7:0] OFS_CLKCTL = 8'h08;
    localparam logic [7:0] OFS_OFFSET = 8'h09;
    localparam logic [7:0] OFS_CTRL   = 8'h0a;
    localparam logic [7:0] OFS_PTR    = 8'h0b;
    localparam logic [7:0] OFS_UNIX0  = 8'h0c;
    localparam logic [7:0] OFS_UNIX3  = 8'h0f;
    // Clock control and control register field positions
    localparam int CC_FSEL_LSB = 0;
    localparam int CC_EN_BIT   = 3;
    localparam int CC_IRQE_BIT = 4;
    localparam int CC_SYNC_BIT = 5;
    localparam int CC_FLAG_BIT = 6;
    localparam int CTRL_RESET_BIT = 0;
    // Reset values
    localparam logic [2:0] FSEL_RST = 3'h0;
    localparam logic       EN_RST   = 1'b1;
    localparam logic       IRQE_RST = 1'b0;
    localparam logic       SYNC_RST = 1'b1;
    localparam logic [7:0] OFFSET_RST = 8'h00;
    // Frequency select codes
    localparam logic [2:0] FSEL_XTAL  = 3'h0;
    localparam logic [2:0] FSEL_8192  = 3'h1;
    localparam logic [2:0] FSEL_1024  = 3'h2;
    localparam logic [2:0] FSEL_64    = 3'h3;
    localparam logic [2:0] FSEL_32    = 3'h4;
    localparam logic [2:0] FSEL_1HZ   = 3'h5;
    localparam logic [2:0] FSEL_TIMER = 3'h6;
    localparam logic [2:0] FSEL_OFF   = 3'h7;
    // Prescaler taps on a 15-bit count of crystal falling edges
    localparam int PRE_W      = 15;
    localparam int TAP_8192   = 1;
    localparam int TAP_1024   = 4;
    localparam int TAP_64     = 8;
    localparam int TAP_32     = 9;
    localparam int TAP_1HZ    = 14;
    localparam int CORR_PERIOD_S = 60;
    // Time counter limits (binary) and read-failure value
    localparam logic [7:0] SEC_MAX  = 8'h3b;
    localparam logic [7:0] MIN_MAX  = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] RD_FAIL  = 8'hff;
    // Bus access timeout
    localparam int CLK_HZ      = 10_000_000;
    localparam int TIMEOUT_MS  = 950;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int TMO_W       = 24;
endpackage : rtc_pkg

//--- dv/rtc_clkout_checker.sv
// Port-level assertions for the clock output and time access block
`timescale 1ns/100ps
module rtc_clkout_checker
    import rtc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       bus_start,
    input wire logic       bus_stop,
    input wire logic       bus_reset,
    input wire logic       counters_frozen,
    input wire logic       xtal_clk,
    input wire logic       backup_supply_state,
    input wire logic       timer_irq,
    input wire logic       clk_out
);
    logic [23:0] frz_cnt_r;
    logic        tmo_r;
    // A fresh START restarts the access timer, so the count restarts with it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) frz_cnt_r <= 24'h000000;
        else if (bus_start || !counters_frozen) frz_cnt_r <= 24'h000000;
        else frz_cnt_r <= frz_cnt_r + 24'h000001;
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) tmo_r <= 1'b0;
        else if (bus_start) tmo_r <= 1'b0;
        else if (bus_reset) tmo_r <= 1'b1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    freeze_on_start_a: assert property (bus_start |=> counters_frozen)
        else $error("counters not frozen after start");
    stop_release_a: assert property (counters_frozen && bus_stop && !bus_start |=> !counters_frozen)
        else $error("counters still frozen after stop");
    no_stray_freeze_a: assert property (!counters_frozen && !bus_start |=> !counters_frozen)
        else $error("freeze without start");
    timeout_bound_a: assert property (frz_cnt_r <= TIMEOUT_CYCLES + 1)
        else $error("freeze outlived the access timeout");
    reset_cause_a: assert property (bus_reset |-> !counters_frozen && $past(counters_frozen))
        else $error("bus reset without a timed-out freeze");
    reset_single_a: assert property (bus_reset |=> !bus_reset)
        else $error("bus reset longer than one cycle");
    read_fail_a: assert property (tmo_r && reg_rd && !bus_start |=> reg_rdata == RD_FAIL)
        else $error("read after timeout not all ones");
    backup_low_a: assert property (backup_supply_state [*4] |=> !clk_out)
        else $error("clock output active in backup supply");
endmodule : rtc_clkout_checker

//--- dv/rtc_far_model.sv
// Far side: free-running crystal and host bus framing pulses
`timescale 1ns/100ps
module rtc_far_model #(
    parameter int XTAL_HALF_NS = 400
) (
    input  wire logic ref_clk,
    output logic      xtal_clk,
    output logic      bus_start,
    output logic      bus_stop
);
    // Sped-up crystal so that divided taps show up within a short run
    initial begin
        xtal_clk = 1'b0;
        bus_start = 1'b0;
        bus_stop = 1'b0;
        forever #(XTAL_HALF_NS) xtal_clk = ~xtal_clk;
    end
    // Host opens one transaction for a whole time access
    task automatic frame_start();
        @(posedge ref_clk);
        bus_start <= 1'b1;
        @(posedge ref_clk);
        bus_start <= 1'b0;
    endtask : frame_start
    task automatic frame_stop();
        @(posedge ref_clk);
        bus_stop <= 1'b1;
        @(posedge ref_clk);
        bus_stop <= 1'b0;
    endtask : frame_stop
endmodule : rtc_far_model

//--- dv/tb_top.sv
// Self-checking bench for the clock output and time access block
`timescale 1ns/100ps
module tb_top;
    import rtc_pkg::*;
    localparam int TMO = 200;
    logic       ref_clk;
    logic       resetn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       bus_start;
    logic       bus_stop;
    logic       bus_reset;
    logic       counters_frozen;
    logic       xtal_clk;
    logic       backup_supply_state;
    logic       timer_irq;
    logic       clk_out;
    int         bad_count;
    int         checks_done;
    int         rises;
    logic [7:0] rd_v;
    int         lo_tab [8] = '{62, 14, 1, 0, 0, 0, 2, 0};
    int         hi_tab [8] = '{65, 17, 3, 1, 1, 1, 3, 0};

    rtc_clkout_time #(.TIMEOUT_CYCLES(TMO)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_start(bus_start),
        .bus_stop(bus_stop), .bus_reset(bus_reset), .counters_frozen(counters_frozen),
        .xtal_clk(xtal_clk), .backup_supply_state(backup_supply_state),
        .timer_irq(timer_irq), .clk_out(clk_out));
    rtc_far_model far_u (.ref_clk(ref_clk), .xtal_clk(xtal_clk), .bus_start(bus_start),
        .bus_stop(bus_stop));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkr(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chkr
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        rd_v = reg_rdata;
        chk8(rd_v, exp);
    endtask : rdchk
    task automatic pulse_irq();
        @(posedge ref_clk);
        timer_irq <= 1'b1;
        @(posedge ref_clk);
        timer_irq <= 1'b0;
    endtask : pulse_irq
    // Rising edges of the output pin over n cycles
    task automatic count(input int n);
        logic prev;
        prev = clk_out;
        rises = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (clk_out === 1'b1 && prev !== 1'b1) rises++;
            prev = clk_out;
        end
    endtask : count
    task automatic stop_wait();
        far_u.frame_stop();
        wait_cyc(20);
    endtask : stop_wait

    initial begin
        wait_cyc(20000);
        bad_count++;
        end_of_test();
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        backup_supply_state = 1'b0;
        timer_irq = 1'b0;
        bad_count = 0;
        checks_done = 0;
        wait_cyc(5);
        resetn <= 1'b1;
        rdchk(OFS_CLKCTL, 8'h28);
        rdchk(OFS_CTRL, 8'h00);
        rdchk(8'h20, 8'h00);
        count(256);
        chkr(rises, 29, 33);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CLKCTL, 8'h20);
            far_u.frame_stop();
            wait_cyc(300);
            wr(OFS_CLKCTL, 8'h28 | 8'(c));
            wait_cyc(20);
            fork
                count(512);
                repeat (3) begin
                    wait_cyc(100);
                    pulse_irq();
                end
            join
            chkr(rises, lo_tab[c], hi_tab[c]);
        end
        // Synced disable must hold off until the bus STOP
        wr(OFS_CLKCTL, 8'h28);
        wait_cyc(20);
        wr(OFS_CLKCTL, 8'h20);
        wait_cyc(20);
        count(256);
        chkr(rises, 29, 33);
        stop_wait();
        count(256);
        chkr(rises, 0, 0);
        wr(OFS_CLKCTL, 8'h30);
        wait_cyc(20);
        count(256);
        chkr(rises, 0, 0);
        pulse_irq();
        wait_cyc(20);
        rdchk(OFS_CLKCTL, 8'h70);
        count(256);
        chkr(rises, 29, 33);
        wr(OFS_CLKCTL, 8'h60);
        rdchk(OFS_CLKCTL, 8'h60);
        count(256);
        chkr(rises, 29, 33);
        wr(OFS_CLKCTL, 8'h20);
        stop_wait();
        pulse_irq();
        count(256);
        chkr(rises, 0, 0);
        rdchk(OFS_CLKCTL, 8'h20);
        wr(OFS_CLKCTL, 8'h28);
        wait_cyc(20);
        @(posedge ref_clk);
        backup_supply_state <= 1'b1;
        wait_cyc(10);
        count(256);
        chkr(rises, 0, 0);
        @(posedge ref_clk);
        backup_supply_state <= 1'b0;
        wait_cyc(20);
        count(256);
        chkr(rises, 29, 33);
        far_u.frame_start();
        @(negedge ref_clk);
        chk8({7'h00, counters_frozen}, 8'h01);
        wr(OFS_MIN, 8'h05);
        far_u.frame_stop();
        @(negedge ref_clk);
        chk8({7'h00, counters_frozen}, 8'h00);
        rdchk(OFS_PTR, 8'h02);
        // Timed-out access: no STOP arrives
        far_u.frame_start();
        for (int i = 0; i < TMO + 20 && bus_reset !== 1'b1; i++) @(negedge ref_clk);
        chk8({7'h00, bus_reset}, 8'h01);
        rdchk(OFS_MIN, RD_FAIL);
        wr(OFS_MIN, 8'h09);
        far_u.frame_start();
        far_u.frame_stop();
        rdchk(OFS_MIN, 8'h05);
        end_of_test();
    end
endmodule : tb_top

bind rtc_clkout_time rtc_clkout_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_start(bus_start),
    .bus_stop(bus_stop), .bus_reset(bus_reset), .counters_frozen(counters_frozen),
    .xtal_clk(xtal_clk), .backup_supply_state(backup_supply_state),
    .timer_irq(timer_irq), .clk_out(clk_out));

//--- hdl/rtc_clkout_time.sv
// Programmable clock output and coherent time counter access
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps

//  Contract
// - Select six frequencies or timer interrupt
// - Raw crystal uncorrected, divided taps offset-corrected
// - Output switching on crystal falling edges
// - Backup supply forces output low
// - Reset: sync on, enable on, select 000
// - Disable on enable clear or select 111
// - Enable bit drives selected frequency
// - Interrupt event sets flag, starts output
// - Irq enable clear keeps output; flag clear stops
// - Synced start on source falling edge
// - Synced stop after STOP, source falling edge
// - Freeze time counters during bus access
// - Remember one tick, apply at STOP
// - Seconds write or reset drops tick, restarts prescaler
// - Prescaler restart shifts all consumers
// - Linear seconds counter never frozen
// - Write timeout: reset bus, keep values, tick
// - Read timeout: read all-ones, tick, resume
// - Address pointer survives STOP and timeout
// - Time write without seconds keeps phase
// - Reset bit restarts prescaler, seconds kept
module rtc_clkout_time
    import rtc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       bus_start,
    input  wire logic       bus_stop,
    output logic            bus_reset,
    output logic            counters_frozen,
    input  wire logic       xtal_clk,
    input  wire logic       backup_supply_state,
    input  wire logic       timer_irq,
    output logic            clk_out
);

    typedef enum logic [1:0] {OUT_OFF, OUT_WAIT_ON, OUT_ON, OUT_WAIT_OFF} rtc_out_e;

    logic            xtal_s1_r, xtal_s2_r, xtal_d_r;
    logic            bkp_s1_r, bkp_s2_r;
    logic            xtal_fall;
    logic [PRE_W-1:0] pre_r;
    logic [5:0]      corr_cnt_r;
    logic            one_hz;
    logic            pre_restart;
    logic [2:0]      frequency_select_field_r;
    logic            clock_out_enable_bit_r;
    logic            irq_driven_output_enable_r;
    logic            synchronized_switch_enable_r;
    logic            clock_out_irq_flag_r;
    logic [7:0]      oscillator_offset_value_r;
    logic [7:0]      time_r [0:6];
    logic [31:0]     unix_r;
    logic [7:0]      ptr_r;
    logic            busy_r;
    logic            pend_r;
    logic            tmo_flag_r;
    logic [TMO_W-1:0] tmo_cnt_r;
    logic            tmo_hit;
    logic            release_acc;
    logic            do_tick;
    logic            wr_ok;
    logic            sec_wr;
    logic            rst_wr;
    logic            stop_seen_r;
    logic            src_level;
    logic            src_prev_r, src_fell_r;
    logic            src_fall;
    logic            out_req;
    rtc_out_e        out_st_r;
    logic [7:0]      rd_mux;
    logic [7:0]      rd_data_r;
    logic            bus_reset_r;
    logic            clk_out_r;

    // Crystal and supply-state pins come from outside this clock domain
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            xtal_s1_r <= 1'b0;
            xtal_s2_r <= 1'b0;
            xtal_d_r  <= 1'b0;
            bkp_s1_r  <= 1'b0;
            bkp_s2_r  <= 1'b0;
        end else begin
            xtal_s1_r <= xtal_clk;
            xtal_s2_r <= xtal_s1_r;
            xtal_d_r  <= xtal_s2_r;
            bkp_s1_r  <= backup_supply_state;
            bkp_s2_r  <= bkp_s1_r;
        end
    end

    assign xtal_fall = xtal_d_r & ~xtal_s2_r;

    // Register port qualifiers; writes are dropped while a timed-out transfer lingers
    assign wr_ok  = reg_wr & ~tmo_flag_r;
    assign sec_wr = wr_ok && (reg_addr == OFS_SEC);
    assign rst_wr = wr_ok && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_RESET_BIT];
    assign pre_restart = sec_wr | rst_wr;

    // Prescaler: divided taps all come from here, so a restart moves every consumer
    assign one_hz = xtal_fall && (pre_r == {PRE_W{1'b1}});

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pre_r      <= '0;
            corr_cnt_r <= '0;
        end else if (pre_restart) begin
            // Bit 0 (16384 Hz) is outside the restarted stages
            pre_r <= {{(PRE_W-1){1'b0}}, pre_r[0]};
        end else if (one_hz) begin
            if (corr_cnt_r == 6'(CORR_PERIOD_S - 1)) begin
                corr_cnt_r <= '0;
                // Offset can only skip counts, so it corrects a slow crystal only
                pre_r <= PRE_W'(oscillator_offset_value_r);
            end else begin
                corr_cnt_r <= corr_cnt_r + 6'h01;
                pre_r      <= '0;
            end
        end else if (xtal_fall) begin
            pre_r <= pre_r + PRE_W'(1);
        end
    end

    // Freeze window and bus timeout
    assign tmo_hit     = busy_r && (tmo_cnt_r == TMO_W'(TIMEOUT_CYCLES - 1));
    assign release_acc = busy_r & (bus_stop | tmo_hit);
    assign do_tick     = (one_hz & ~busy_r) | (release_acc & pend_r & ~pre_restart);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_r     <= 1'b0;
            tmo_cnt_r  <= '0;
            tmo_flag_r <= 1'b0;
            bus_reset_r <= 1'b0;
        end else begin
            bus_reset_r <= tmo_hit;
            if (bus_start) begin
                busy_r     <= 1'b1;
                tmo_cnt_r  <= '0;
                tmo_flag_r <= 1'b0;
            end else if (release_acc) begin
                busy_r     <= 1'b0;
                tmo_cnt_r  <= '0;
                tmo_flag_r <= tmo_hit;
            end else if (busy_r) begin
                tmo_cnt_r <= tmo_cnt_r + TMO_W'(1);
            end
        end
    end

    // One remembered tick; a seconds write or reset bit throws it away
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pend_r <= 1'b0;
        end else if (pre_restart) begin
            pend_r <= 1'b0;
        end else if (release_acc) begin
            pend_r <= 1'b0;
        end else if (busy_r && one_hz) begin
            pend_r <= 1'b1;
        end
    end

    // Time counters; only seconds, minutes and hours carry, the rest are held as written
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 7; i++) begin
                time_r[i] <= 8'h00;
            end
        end else if (wr_ok && (reg_addr <= OFS_TLAST)) begin
            time_r[reg_addr[2:0]] <= reg_wdata;
        end else if (do_tick) begin
            if (time_r[OFS_SEC[2:0]] >= SEC_MAX) begin
                time_r[OFS_SEC[2:0]] <= 8'h00;
                if (time_r[OFS_MIN[2:0]] >= MIN_MAX) begin
                    time_r[OFS_MIN[2:0]] <= 8'h00;
                    if (time_r[OFS_HOUR[2:0]] >= HOUR_MAX) begin
                        time_r[OFS_HOUR[2:0]] <= 8'h00;
                    end else begin
                        time_r[OFS_HOUR[2:0]] <= time_r[OFS_HOUR[2:0]] + 8'h01;
                    end
                end else begin
                    time_r[OFS_MIN[2:0]] <= time_r[OFS_MIN[2:0]] + 8'h01;
                end
            end else begin
                time_r[OFS_SEC[2:0]] <= time_r[OFS_SEC[2:0]] + 8'h01;
            end
        end
    end

    // Linear seconds counter ignores the freeze
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            unix_r <= '0;
        end else if (one_hz) begin
            unix_r <= unix_r + 32'h0000_0001;
        end
    end

    // Auto-increment pointer; neither STOP nor timeout touch it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ptr_r <= 8'h00;
        end else if (reg_wr || reg_rd) begin
            ptr_r <= reg_addr + 8'h01;
        end
    end

    // Clock output configuration
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            frequency_select_field_r     <= FSEL_RST;
            clock_out_enable_bit_r       <= EN_RST;
            irq_driven_output_enable_r   <= IRQE_RST;
            synchronized_switch_enable_r <= SYNC_RST;
            oscillator_offset_value_r    <= OFFSET_RST;
        end else if (wr_ok && (reg_addr == OFS_CLKCTL)) begin
            frequency_select_field_r     <= reg_wdata[CC_FSEL_LSB +: 3];
            clock_out_enable_bit_r       <= reg_wdata[CC_EN_BIT];
            irq_driven_output_enable_r   <= reg_wdata[CC_IRQE_BIT];
            synchronized_switch_enable_r <= reg_wdata[CC_SYNC_BIT];
        end else if (wr_ok && (reg_addr == OFS_OFFSET)) begin
            oscillator_offset_value_r <= reg_wdata;
        end
    end

    // Flag: a trigger in the same cycle as a clearing write wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clock_out_irq_flag_r <= 1'b0;
        end else if (timer_irq && irq_driven_output_enable_r && !clock_out_enable_bit_r) begin
            clock_out_irq_flag_r <= 1'b1;
        end else if (wr_ok && (reg_addr == OFS_CLKCTL) && !reg_wdata[CC_FLAG_BIT]) begin
            clock_out_irq_flag_r <= 1'b0;
        end
    end

    // Source selection
    always_comb begin
        case (frequency_select_field_r)
            FSEL_XTAL:  src_level = xtal_s2_r;
            FSEL_8192:  src_level = pre_r[TAP_8192];
            FSEL_1024:  src_level = pre_r[TAP_1024];
            FSEL_64:    src_level = pre_r[TAP_64];
            FSEL_32:    src_level = pre_r[TAP_32];
            FSEL_1HZ:   src_level = pre_r[TAP_1HZ];
            FSEL_TIMER: src_level = timer_irq;
            default:    src_level = 1'b0;
        endcase
    end

    assign out_req  = clock_out_irq_flag_r | clock_out_enable_bit_r;
    assign src_fall = src_prev_r & ~src_level;

    // Keep a STOP after the request drops, and a tap fall, which lands just after a crystal edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            src_prev_r  <= 1'b0;
            src_fell_r  <= 1'b0;
            stop_seen_r <= 1'b0;
        end else begin
            src_prev_r <= src_level;
            src_fell_r <= !xtal_fall && (src_fall || src_fell_r);
            if (out_req) begin
                stop_seen_r <= 1'b0;
            end else if (bus_stop) begin
                stop_seen_r <= 1'b1;
            end
        end
    end

    // On/off state moves only on crystal falling edges
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            out_st_r <= OUT_ON;
        end else if (xtal_fall) begin
            case (out_st_r)
                OUT_OFF: begin
                    if (out_req && frequency_select_field_r != FSEL_OFF) begin
                        out_st_r <= synchronized_switch_enable_r ? OUT_WAIT_ON : OUT_ON;
                    end
                end
                OUT_WAIT_ON: begin
                    if (!out_req) begin
                        out_st_r <= OUT_OFF;
                    end else if (src_fall || src_fell_r) begin
                        out_st_r <= OUT_ON;
                    end
                end
                OUT_ON: begin
                    if (frequency_select_field_r == FSEL_OFF) begin
                        out_st_r <= OUT_OFF;
                    end else if (!out_req) begin
                        out_st_r <= synchronized_switch_enable_r ? OUT_WAIT_OFF : OUT_OFF;
                    end
                end
                OUT_WAIT_OFF: begin
                    if (out_req) begin
                        out_st_r <= OUT_ON;
                    end else if (stop_seen_r && (src_fall || !src_level)) begin
                        out_st_r <= OUT_OFF;
                    end
                end
                default: out_st_r <= OUT_OFF;
            endcase
        end
    end

    // Pin level; backup supply overrides everything
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clk_out_r <= 1'b0;
        end else begin
            clk_out_r <= ~bkp_s2_r && src_level &&
                         (out_st_r == OUT_ON || out_st_r == OUT_WAIT_OFF);
        end
    end

    // Read path
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr <= OFS_TLAST) begin
            rd_mux = time_r[reg_addr[2:0]];
        end else if (reg_addr == OFS_CLKCTL) begin
            rd_mux = {1'b0, clock_out_irq_flag_r, synchronized_switch_enable_r,
                      irq_driven_output_enable_r, clock_out_enable_bit_r,
                      frequency_select_field_r};
        end else if (reg_addr == OFS_OFFSET) begin
            rd_mux = oscillator_offset_value_r;
        end else if (reg_addr == OFS_PTR) begin
            rd_mux = ptr_r;
        end else if (reg_addr >= OFS_UNIX0 && reg_addr <= OFS_UNIX3) begin
            rd_mux = unix_r[8*reg_addr[1:0] +: 8];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_r <= 8'h00;
        end else if (reg_rd) begin
            rd_data_r <= tmo_flag_r ? RD_FAIL : rd_mux;
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    assign reg_rdata       = rd_data_r;
    assign bus_reset       = bus_reset_r;
    assign counters_frozen = busy_r;
    assign clk_out         = clk_out_r;

endmodule : rtc_clkout_time
